// [hdl/band_relay_pkg.sv]
// Constants shared by the band filter relay driver.
package band_relay_pkg;
	// Frequency is tuned value in Hz, 25 bits covers 0..30 MHz
	localparam int unsigned FREQ_W          = 25;
	localparam int unsigned RELAY_LINES     = 6;
	localparam int unsigned BAND_W          = 4;

	// Lower edges of bands 2..11, in Hz
	localparam logic [24:0] EDGE_B2         = 25'd1800000;
	localparam logic [24:0] EDGE_B3         = 25'd3500000;
	localparam logic [24:0] EDGE_B4         = 25'd7000000;
	localparam logic [24:0] EDGE_B5         = 25'd10100000;
	localparam logic [24:0] EDGE_B6         = 25'd14000000;
	localparam logic [24:0] EDGE_B7         = 25'd18068000;
	localparam logic [24:0] EDGE_B8         = 25'd21000000;
	localparam logic [24:0] EDGE_B9         = 25'd24890000;
	localparam logic [24:0] EDGE_B10        = 25'd28000000;
	localparam logic [24:0] EDGE_B11        = 25'd30000000;

	// Pulse timing
	localparam int unsigned CLK_HZ          = 250000000;
	localparam int unsigned PULSE_MS        = 8;
	localparam int unsigned PULSE_CYCLES    = CLK_HZ / 1000 * PULSE_MS;
	localparam int unsigned CNT_W           = 21;

	// Reset values
	localparam logic [3:0]  BAND_RST        = 4'h0;
	localparam logic [5:0]  HDR_RST         = 6'h00;
	localparam logic [2:0]  RELAY_NONE      = 3'h0;
endpackage : band_relay_pkg

// [hdl/band_classifier.sv]
// Frequency to band number and filter relay mapping.
`timescale 1ns/1ps
`default_nettype none
module band_classifier
	import band_relay_pkg::*;
(
	input  wire logic [FREQ_W-1:0] freq_i,
	output logic      [3:0]        band_o,
	output logic      [2:0]        relay_o
);
	always_comb begin
		if (freq_i < EDGE_B2) begin
			band_o  = 4'h1;
			relay_o = 3'h1;
		end else if (freq_i < EDGE_B3) begin
			band_o  = 4'h2;
			relay_o = 3'h1;
		end else if (freq_i < EDGE_B4) begin
			band_o  = 4'h3;
			relay_o = 3'h2;
		end else if (freq_i < EDGE_B5) begin
			band_o  = 4'h4;
			relay_o = 3'h3;
		end else if (freq_i < EDGE_B6) begin
			band_o  = 4'h5;
			relay_o = 3'h3;
		end else if (freq_i < EDGE_B7) begin
			band_o  = 4'h6;
			relay_o = 3'h4;
		end else if (freq_i < EDGE_B8) begin
			band_o  = 4'h7;
			relay_o = 3'h5;
		end else if (freq_i < EDGE_B9) begin
			band_o  = 4'h8;
			relay_o = 3'h5;
		end else if (freq_i < EDGE_B10) begin
			band_o  = 4'h9;
			relay_o = 3'h5;
		end else if (freq_i < EDGE_B11) begin
			band_o  = 4'hA;
			relay_o = 3'h5;
		end else begin
			// Anything at or above 30 MHz stays on the widest filter
			band_o  = 4'hB;
			relay_o = 3'h5;
		end
	end
endmodule : band_classifier
`default_nettype wire

// [hdl/band_filter_relay_driver.sv]
// Band relay header and quadrature swap relay pulse sequencer.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Below 3.5 MHz: bands 1,2, relay 1
// - 3.5 to 7 MHz: band 3, relay 2
// - 7 to 14 MHz: bands 4,5, relay 3
// - 14 to 18.068 MHz: band 6, relay 4
// - 18.068 MHz up: bands 7-11, relay 5
// - Sixth header line high only in reset phases
// - Set: all lines low, chosen high
// - Set pulse holds 8 ms then low
// - Reset: all lines high, chosen low
// - Reset ends in the new relay's set after 8 ms
// - Band crossing that changes relay triggers pulses
// - Sideband press drives quadrature swap relay
module band_filter_relay_driver
	import band_relay_pkg::*;
#(
	// Pulse length in clocks; shortened only by the bench to keep runs short
	parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
	input  wire logic              mclk_i,
	input  wire logic              reset_i,
	input  wire logic [FREQ_W-1:0] freq_i,
	input  wire logic              sideband_press_i,
	output logic      [5:0]        band_relay_header_o,
	output logic                   quadrature_swap_relay_set_o,
	output logic                   quadrature_swap_relay_reset_o,
	output logic                   quadrature_swap_state_o,
	output logic      [3:0]        band_o,
	output logic                   busy_o
);
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_RST   = 5'b00010,
		ST_SET   = 5'b00100,
		ST_SWAP  = 5'b01000,
		ST_START = 5'b10000
	} seq_state_e;

	// One-hot header pattern for relay numbers 1..5; relay 6 is never coded
	function automatic logic [5:0] relay_mask(input logic [2:0] num);
		logic [5:0] m;
		m = 6'h00;
		case (num)
			3'h1:    m = 6'h01;
			3'h2:    m = 6'h02;
			3'h3:    m = 6'h04;
			3'h4:    m = 6'h08;
			3'h5:    m = 6'h10;
			default: m = 6'h00;
		endcase
		return m;
	endfunction : relay_mask

	logic [3:0] cls_band;
	logic [2:0] cls_relay;

	band_classifier u_classifier (
		.freq_i  (freq_i),
		.band_o  (cls_band),
		.relay_o (cls_relay)
	);

	seq_state_e       state_r,     state_nxt;
	logic [CNT_W-1:0] cnt_r,       cnt_nxt;
	logic [3:0]       band_r,      band_nxt;
	logic [2:0]       relay_r,     relay_nxt;
	logic [2:0]       old_relay_r, old_relay_nxt;
	logic [5:0]       hdr_r,       hdr_nxt;
	logic             swap_r,      swap_nxt;
	logic             swap_set_r,  swap_set_nxt;
	logic             swap_rst_r,  swap_rst_nxt;
	logic             press_pend_r, press_pend_nxt;
	logic             press_d_r,   press_d_nxt;
	logic             press_edge;
	logic             cnt_done;

	localparam logic [CNT_W-1:0] PULSE_LAST = CNT_W'(PULSE_LEN - 1);

	assign press_edge = sideband_press_i & ~press_d_r;
	assign cnt_done   = (cnt_r == PULSE_LAST);

	always_comb begin
		state_nxt      = state_r;
		cnt_nxt        = cnt_r;
		band_nxt       = band_r;
		relay_nxt      = relay_r;
		old_relay_nxt  = old_relay_r;
		hdr_nxt        = hdr_r;
		swap_nxt       = swap_r;
		swap_set_nxt   = swap_set_r;
		swap_rst_nxt   = swap_rst_r;
		press_d_nxt    = sideband_press_i;
		// Press caught during a pulse is held, not lost
		press_pend_nxt = press_pend_r | press_edge;
		case (state_r)
			ST_START: begin
				// First classification after reset sets the relay without a reset pulse
				band_nxt  = cls_band;
				relay_nxt = cls_relay;
				hdr_nxt   = relay_mask(cls_relay);
				cnt_nxt   = '0;
				state_nxt = ST_SET;
			end
			ST_IDLE: begin
				cnt_nxt = '0;
				if (press_pend_r | press_edge) begin
					press_pend_nxt = 1'b0;
					swap_nxt       = ~swap_r;
					swap_set_nxt   = ~swap_r;
					swap_rst_nxt   = swap_r;
					state_nxt      = ST_SWAP;
				end else if (cls_band != band_r) begin
					band_nxt      = cls_band;
					relay_nxt     = cls_relay;
					old_relay_nxt = relay_r;
					if (cls_relay != relay_r) begin
						// Old relay first: all lines high, its line low
						hdr_nxt   = ~relay_mask(relay_r);
						state_nxt = ST_RST;
					end
					// Same filter for the new band: nothing to pulse
				end
			end
			ST_RST: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_done) begin
					cnt_nxt   = '0;
					hdr_nxt   = relay_mask(relay_r);
					state_nxt = ST_SET;
				end
			end
			ST_SET: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_done) begin
					cnt_nxt   = '0;
					hdr_nxt   = HDR_RST;
					state_nxt = ST_IDLE;
				end
			end
			ST_SWAP: begin
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_done) begin
					cnt_nxt      = '0;
					swap_set_nxt = 1'b0;
					swap_rst_nxt = 1'b0;
					state_nxt    = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				hdr_nxt   = HDR_RST;
			end
		endcase
		// Band changes are seen only in idle, so they wait for the pulse to end
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			state_r      <= ST_START;
			cnt_r        <= '0;
			band_r       <= BAND_RST;
			relay_r      <= RELAY_NONE;
			old_relay_r  <= RELAY_NONE;
			hdr_r        <= HDR_RST;
			swap_r       <= 1'b0;
			swap_set_r   <= 1'b0;
			swap_rst_r   <= 1'b0;
			press_pend_r <= 1'b0;
			press_d_r    <= 1'b0;
		end else begin
			state_r      <= state_nxt;
			cnt_r        <= cnt_nxt;
			band_r       <= band_nxt;
			relay_r      <= relay_nxt;
			old_relay_r  <= old_relay_nxt;
			hdr_r        <= hdr_nxt;
			swap_r       <= swap_nxt;
			swap_set_r   <= swap_set_nxt;
			swap_rst_r   <= swap_rst_nxt;
			press_pend_r <= press_pend_nxt;
			press_d_r    <= press_d_nxt;
		end
	end

	assign band_relay_header_o           = hdr_r;
	assign quadrature_swap_relay_set_o   = swap_set_r;
	assign quadrature_swap_relay_reset_o = swap_rst_r;
	assign quadrature_swap_state_o       = swap_r;
	assign band_o                        = band_r;
	assign busy_o                        = (state_r != ST_IDLE);
endmodule : band_filter_relay_driver
`default_nettype wire

// [tb/band_filter_relay_driver_monitor.sv]
// Port checker for the band relay driver.
`timescale 1ns/1ps
`default_nettype none
module band_filter_relay_driver_monitor
	import band_relay_pkg::*;
#(
	parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic [5:0] band_relay_header_o,
	input wire logic       quadrature_swap_relay_set_o,
	input wire logic       quadrature_swap_relay_reset_o,
	input wire logic       quadrature_swap_state_o,
	input wire logic [3:0] band_o,
	input wire logic       busy_o
);
	logic [5:0]       h, hd_r, m;
	logic             qs, qr;
	logic [CNT_W-1:0] hc_r, qc_r;
	assign h = band_relay_header_o;
	assign qs = quadrature_swap_relay_set_o;
	assign qr = quadrature_swap_relay_reset_o;
	// Set pattern of the relay that serves the current band
	assign m = band_o < 4'h3 ? 6'h01 : band_o == 4'h3 ? 6'h02 : band_o < 4'h6 ? 6'h04 : band_o == 4'h6 ? 6'h08 : 6'h10;
	// Counters only need to reach one pulse; a longer hold is already a fault
	always_ff @(posedge mclk_i) begin
		hd_r <= reset_i ? 6'h00 : h;
		hc_r <= (reset_i || h != hd_r) ? CNT_W'(1) : hc_r + 1'b1;
		qc_r <= (reset_i || !(qs || qr)) ? '0 : qc_r + 1'b1;
	end
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	AST_SHAPE: assert property (h == 6'h00 || (h[5] ? $onehot(~h[4:0]) : $onehot(h[4:0])))
		else $error("bad header");
	AST_LEN: assert property (h != hd_r && hd_r != 6'h00 |-> hc_r == PULSE_LEN)
		else $error("header phase length");
	AST_ORDER: assert property (h != hd_r && hd_r[5] |-> h == m)
		else $error("no set after reset");
	AST_MAP: assert property (h != 6'h00 && !h[5] |-> h == m)
		else $error("relay for band");
	AST_BUSY: assert property (h != 6'h00 || qs || qr |-> busy_o)
		else $error("pulse while idle");
	AST_ONE: assert property (!(qs && qr) && !((qs || qr) && h != 6'h00))
		else $error("two pulses");
	AST_QLEN: assert property ($fell(qs || qr) |-> qc_r == PULSE_LEN)
		else $error("swap pulse length");
	AST_QST: assert property ($rose(qs || qr) |-> quadrature_swap_state_o == qs)
		else $error("swap state");
endmodule : band_filter_relay_driver_monitor
bind band_filter_relay_driver band_filter_relay_driver_monitor #(.PULSE_LEN(PULSE_LEN)) u_mon (.mclk_i, .reset_i,
	.band_relay_header_o,
	.quadrature_swap_relay_set_o, .quadrature_swap_relay_reset_o, .quadrature_swap_state_o, .band_o, .busy_o);
`default_nettype wire

// [tb/relay_board_model.sv]
// Latching filter relays and swap relay on the far board.
`timescale 1ns/1ps
`default_nettype none
module relay_board_model
	import band_relay_pkg::*;
#(
	parameter int unsigned PULSE_LEN = PULSE_CYCLES
)
(
	input  wire logic       mclk_i,
	input  wire logic [5:0] hdr_i,
	input  wire logic       set_i,
	input  wire logic       clr_i,
	output logic      [4:0] relays_o,
	output logic            swap_o
);
	logic [5:0] last_r = 6'h00;
	int         cnt_r = 0;
	initial relays_o = 5'h00;
	initial swap_o = 1'b0;
	// A filter relay coil flips only after a full-length drive; the swap relay follows set/clear at once
	always @(posedge mclk_i) begin
		cnt_r <= (hdr_i == last_r) ? cnt_r + 1 : 1;
		last_r <= hdr_i;
		if (hdr_i != last_r && cnt_r >= PULSE_LEN)
			relays_o <= last_r[5] ? relays_o & last_r[4:0] : relays_o | last_r[4:0];
		if (set_i || clr_i)
			swap_o <= set_i;
	end
endmodule : relay_board_model
`default_nettype wire

// [tb/band_filter_relay_driver_tb_top.sv]
// Self-checking bench for the band relay driver.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) n_compared++; if ((g) !== (e)) begin failures++; $display("FAIL %s exp %0h got %0h", nm, e, g); end
module band_filter_relay_driver_tb_top
	import band_relay_pkg::*;
;
	// Short pulse so that the whole run stays a few hundred clocks
	localparam int unsigned PL = 50;
	logic              mclk_i = 1'b0;
	logic              reset_i = 1'b1;
	logic              sideband_press_i = 1'b0;
	logic [FREQ_W-1:0] freq_i = 25'h3567DF;
	logic [5:0]        hdr;
	logic [4:0]        lat;
	logic [3:0]        band;
	logic              qs, qr, qst, busy, swp;
	int                failures = 0, n_compared = 0, cyc = 0;
	band_filter_relay_driver #(.PULSE_LEN(PL)) u_band_filter_relay_driver (.mclk_i, .reset_i, .freq_i,
		.sideband_press_i,
		.band_relay_header_o(hdr), .quadrature_swap_relay_set_o(qs), .quadrature_swap_relay_reset_o(qr),
		.quadrature_swap_state_o(qst), .band_o(band), .busy_o(busy));
	relay_board_model #(.PULSE_LEN(PL)) u_relay_board_model (.mclk_i, .hdr_i(hdr), .set_i(qs), .clr_i(qr),
		.relays_o(lat), .swap_o(swp));
	initial forever #2 mclk_i = ~mclk_i;
	task automatic wt(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : wt
	task automatic wrap_up;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up
	// Seven short pulse phases make the run; ceiling leaves ample margin
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 32'h000007D0) begin
			failures++;
			wrap_up();
		end
	end
	task automatic t_power_up;
		wt(2);
		`CHK("hdr", 6'h01, hdr)
		`CHK("band", 4'h2, band)
		wt(PL);
		`CHK("latched", 6'h01, {hdr, lat})
		freq_i = 25'h1B773F;
		wt(3);
		`CHK("band same relay", 6'h01, {hdr, busy, band})
	endtask : t_power_up
	task automatic t_queued;
		freq_i = 25'h09A1D20;
		wt(2);
		`CHK("reset phase", 10'h3E5, {hdr, band})
		freq_i = 25'h113B220;
		wt(PL);
		`CHK("set phase", 11'h080, {hdr, lat})
		wt(PL + 3);
		`CHK("queued", 15'h76E4, {hdr, band, lat})
		wt(2 * PL + 4);
		`CHK("done", 12'h010, {hdr, busy, lat})
	endtask : t_queued
	task automatic t_relay5;
		logic [24:0] f [8] = '{25'h1406F3F, 25'h1406F40, 25'h17BCA8F, 25'h17BCA90,
			25'h1AB3EFF, 25'h1AB3F00, 25'h1C9C37F, 25'h1C9C380};
		for (int i = 0; i < 8; i++) begin
			freq_i = f[i];
			wt(3);
			`CHK("band", 10'(7 + (i + 1) / 2), {hdr, band})
		end
	endtask : t_relay5
	task automatic t_press;
		for (int i = 0; i < 2; i++) begin
			sideband_press_i = 1'b1;
			wt(3);
			`CHK("swap drive", 3'h5 >> i, {qs, qr, qst})
			sideband_press_i = 1'b0;
			wt(PL + 2);
			`CHK("swap latch", 3'(1 - i), {qs, qr, swp})
		end
	endtask : t_press
	initial begin
		wt(12);
		reset_i = 1'b0;
		t_power_up();
		t_queued();
		t_relay5();
		t_press();
		wrap_up();
	end
endmodule : band_filter_relay_driver_tb_top
`default_nettype wire
